// ### rtl/mvic_pkg.sv
// Package of constants and types for the multilevel vectored interrupt controller.
package mvic_pkg;

	// Number of interrupt sources and vectors.
	localparam int NUM_SRC = 31;
	localparam int NUM_VEC = 10;
	localparam int VEC_W   = 4;

	// Source bit positions, grouped by the vector that they share.
	localparam int SRC_EXT0      = 0;
	localparam int SRC_EXT1      = 1;
	localparam int SRC_EXT2      = 2;
	localparam int SRC_TMR0_LOW  = 3;
	localparam int SRC_EXT4      = 4;
	localparam int SRC_IR_FIRST  = 5;
	localparam int SRC_EXT3      = 6;
	localparam int SRC_BASE_TMR  = 7;
	localparam int SRC_EXT5      = 8;
	localparam int SRC_IR_SECOND = 9;
	localparam int SRC_TMR0_HIGH = 10;
	localparam int SRC_EXT6      = 11;
	localparam int SRC_TMR1_LOW  = 12;
	localparam int SRC_TMR1_HIGH = 13;
	localparam int SRC_EXT7      = 14;
	localparam int SRC_SYNC_SER1 = 15;
	localparam int SRC_UART1_RX  = 16;
	localparam int SRC_UART2_RX  = 17;
	localparam int SRC_TMR8_LOW  = 18;
	localparam int SRC_TMR8_HIGH = 19;
	localparam int SRC_SYNC_SER2 = 20;
	localparam int SRC_UART1_TX  = 21;
	localparam int SRC_UART2_TX  = 22;
	localparam int SRC_ADC       = 23;
	localparam int SRC_MIC       = 24;
	localparam int SRC_TMR6      = 25;
	localparam int SRC_TMR7      = 26;
	localparam int SRC_PWM4      = 27;
	localparam int SRC_PWM5      = 28;
	localparam int SRC_PORT0     = 29;
	localparam int SRC_TMR45     = 30;

	// Vector index of each source; index 0 is the smallest vector address.
	localparam logic [NUM_SRC*VEC_W-1:0] SRC_VEC_MAP = {
		4'h9, 4'h9,
		4'h8, 4'h8, 4'h8, 4'h8, 4'h8, 4'h8,
		4'h7, 4'h7, 4'h7,
		4'h6, 4'h6, 4'h6, 4'h6, 4'h6,
		4'h5, 4'h5, 4'h5,
		4'h4, 4'h4,
		4'h3, 4'h3, 4'h3, 4'h3,
		4'h2, 4'h2, 4'h2, 4'h2,
		4'h1, 4'h0
	};

	// Vector addresses of the ten vectors.
	localparam logic [19:0] VEC_BASE_ADDR = 20'h0_0003;
	localparam logic [19:0] VEC_ADDR_STEP = 20'h0_0008;

	// Vectors that may use the highest level instead of high.
	localparam logic [NUM_VEC-1:0] VEC_TOP_CAPABLE = 10'h003;

	// Reset value of the per-vector level select: every vector at low.
	localparam logic [NUM_VEC-1:0] LEVEL_SEL_RESET = 10'h000;

	// Priority levels, ordered so that a larger code is a higher level.
	typedef enum logic [1:0] {
		MVIC_LVL_NONE    = 2'b00,
		MVIC_LVL_LOW     = 2'b01,
		MVIC_LVL_HIGH    = 2'b10,
		MVIC_LVL_HIGHEST = 2'b11
	} mvic_level_type;

	// Standby modes of the core.
	typedef enum logic [1:0] {
		MVIC_RUN       = 2'b00,
		MVIC_HALT      = 2'b01,
		MVIC_HOLD      = 2'b10,
		MVIC_XTAL_HOLD = 2'b11
	} mvic_mode_type;

endpackage

// ### rtl/mvic_arbiter.sv
// Combinational arbiter that picks the winning vector among pending requests.
`timescale 1ns/1ps
module mvic_arbiter
	import mvic_pkg::*;
#(
	parameter int VECS = NUM_VEC
) (
	input  wire logic [VECS-1:0]   vec_req,
	input  wire logic [2*VECS-1:0] vec_level,
	input  wire logic [1:0]        level_in_service,
	output logic                   win_valid,
	output logic [VEC_W-1:0]       win_vec,
	output logic [1:0]             win_level
);

	initial begin
		if (VECS < 1 || VECS > 16) begin
			$error("mvic_arbiter: VECS out of range");
		end
	end

	// Scan from the largest vector down so the smallest index at the best level ends up held.
	always_comb begin
		win_valid = 1'b0;
		win_vec   = '0;
		win_level = 2'b00;
		for (int v = VECS - 1; v >= 0; v--) begin
			// Only strictly higher levels than the one in service may compete.
			if (vec_req[v] && vec_level[2*v +: 2] > level_in_service &&
				vec_level[2*v +: 2] >= win_level) begin
				win_valid = 1'b1;
				win_vec   = VEC_W'(v);
				win_level = vec_level[2*v +: 2];
			end
		end
	end

endmodule

// ### rtl/mvic_ctrl.sv
// Top of the multilevel vectored interrupt controller with standby wake logic.
//
// Behaviour
// - Three levels: highest above high above low.
// - Refuse requests not above level in service.
// - Simultaneous requests: highest level wins.
// - Same level: smallest vector address wins.
// - Thirty-one sources ORed onto ten vectors.
// - Fourth vector: irq three, base timer, irq five, receiver.
// - Seventh vector: serial one, UART receivers, timer eight.
// - Eighth vector: serial two, UART transmitters.
// - Readable list of flags that caused branch.
// - Halt ends on reset or acceptable interrupt.
// - Hold ends on irq zero-two, four, five levels or port.
// - Crystal hold also wakes on base timer, receiver.
// - Entering hold stops all system oscillators.
`timescale 1ns/1ps
module mvic_ctrl
	import mvic_pkg::*;
#(
	parameter int SRCS = NUM_SRC,
	parameter int VECS = NUM_VEC,
	parameter int DEPTH = 3
) (
	input  wire logic               ref_clk,
	input  wire logic               rst_n,
	input  wire logic [SRCS-1:0]    src_flag,
	input  wire logic [VECS-1:0]    level_sel_high,
	input  wire logic               core_ack,
	input  wire logic               core_return,
	input  wire logic [VEC_W-1:0]   list_vec_sel,
	input  wire logic               halt_enter,
	input  wire logic               hold_enter,
	input  wire logic               xtal_hold_enter,
	input  wire logic [7:0]         port0_irq,
	output logic                    irq_req,
	output logic [19:0]             irq_vec_addr,
	output logic [1:0]              irq_level,
	output logic [1:0]              level_in_service,
	output logic [SRCS-1:0]         vector_source_flag_list,
	output logic [1:0]              standby_mode,
	output logic                    osc_main_run,
	output logic                    osc_xtal_run,
	output logic                    core_wake
);

	initial begin
		if (SRCS != NUM_SRC || VECS != NUM_VEC || DEPTH < 1 || DEPTH > 3) begin
			$error("mvic_ctrl: unsupported parameter values");
		end
	end

	// Returns the vector index that a given source belongs to.
	function automatic logic [VEC_W-1:0] src_vec(input int s);
		src_vec = SRC_VEC_MAP[s*VEC_W +: VEC_W];
	endfunction

	// Level code of a vector from its one select bit.
	function automatic logic [1:0] vec_lvl(input int v, input logic sel);
		if (!sel) begin
			vec_lvl = MVIC_LVL_LOW;
		end else if (VEC_TOP_CAPABLE[v]) begin
			vec_lvl = MVIC_LVL_HIGHEST;
		end else begin
			vec_lvl = MVIC_LVL_HIGH;
		end
	endfunction

	logic [VECS-1:0]   vec_req;        // ORed request per vector.
	logic [2*VECS-1:0] vec_level;      // Level of every vector.
	logic              win_valid;      // Some vector may be taken now.
	logic [VEC_W-1:0]  win_vec;        // Winning vector.
	logic [1:0]        win_level;      // Level of the winning vector.
	logic [1:0]        lvl_stack [DEPTH]; // Levels of nested services, top at index 0.
	logic [VEC_W-1:0]  pend_vec;       // Vector presented to the core.
	logic [1:0]        mode;           // Current standby mode.
	logic              accept;         // Core takes the presented request.
	logic              hold_wake;      // Wake events for either hold mode.
	logic              xtal_wake;      // Extra wake events in crystal hold.

	// Each source feeds the request of its own vector; the flag itself is the pending state.
	always_comb begin
		vec_req = '0;
		for (int s = 0; s < SRCS; s++) begin
			if (src_flag[s]) begin
				vec_req[src_vec(s)] = 1'b1;
			end
		end
	end

	// Level assignment per vector.
	always_comb begin
		vec_level = '0;
		for (int v = 0; v < VECS; v++) begin
			vec_level[2*v +: 2] = vec_lvl(v, level_sel_high[v]);
		end
	end

	// Arbitration among vectors, gated by the level in service.
	mvic_arbiter #(
		.VECS(VECS)
	) u_arb (
		.vec_req         (vec_req),
		.vec_level       (vec_level),
		.level_in_service(lvl_stack[0]),
		.win_valid       (win_valid),
		.win_vec         (win_vec),
		.win_level       (win_level)
	);

	// A request is accepted whenever it is presented and the core acks it.
	assign accept = irq_req && core_ack;

	// Wake conditions: edge/level detection of pins is done before the flags reach this block.
	assign hold_wake = src_flag[SRC_EXT0] | src_flag[SRC_EXT1] | src_flag[SRC_EXT2] |
		src_flag[SRC_EXT4] | src_flag[SRC_EXT5] | (|port0_irq);
	assign xtal_wake = src_flag[SRC_BASE_TMR] | src_flag[SRC_IR_FIRST] | src_flag[SRC_IR_SECOND];

	// Presentation to the core. The request drops for one cycle after an accept and stays low outside run mode.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_req      <= 1'b0;
			irq_vec_addr <= 20'h0_0000;
			irq_level    <= 2'b00;
			pend_vec     <= '0;
		end else begin
			irq_req      <= win_valid && !accept && mode == MVIC_RUN;
			irq_vec_addr <= VEC_BASE_ADDR + 20'(win_vec) * VEC_ADDR_STEP;
			irq_level    <= win_level;
			pend_vec     <= win_vec;
		end
	end

	// Nesting stack of service levels; a return pops one level.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				lvl_stack[i] <= MVIC_LVL_NONE;
			end
		end else if (accept && irq_level > lvl_stack[0]) begin
			lvl_stack[0] <= irq_level;
			for (int i = 1; i < DEPTH; i++) begin
				lvl_stack[i] <= lvl_stack[i-1];
			end
		end else if (core_return) begin
			for (int i = 0; i < DEPTH - 1; i++) begin
				lvl_stack[i] <= lvl_stack[i+1];
			end
			lvl_stack[DEPTH-1] <= MVIC_LVL_NONE;
		end
	end

	// Snapshot of the flags of the taken vector, or of the vector that software selects.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			vector_source_flag_list <= '0;
			level_in_service        <= 2'b00;
		end else begin
			for (int s = 0; s < SRCS; s++) begin
				vector_source_flag_list[s] <= src_flag[s] &&
					src_vec(s) == (accept ? pend_vec : list_vec_sel);
			end
			level_in_service <= lvl_stack[0];
		end
	end

	// Standby mode sequencing; hold wins over halt when both are asked at once.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode <= MVIC_RUN; // Reset also ends every standby mode.
		end else begin
			case (mode)
				MVIC_RUN: begin
					if (xtal_hold_enter) begin
						mode <= MVIC_XTAL_HOLD;
					end else if (hold_enter) begin
						mode <= MVIC_HOLD;
					end else if (halt_enter) begin
						mode <= MVIC_HALT;
					end
				end
				MVIC_HALT: begin
					// Any interrupt that could be accepted ends halt.
					if (win_valid) begin
						mode <= MVIC_RUN;
					end
				end
				MVIC_HOLD: begin
					if (hold_wake) begin
						mode <= MVIC_RUN;
					end
				end
				MVIC_XTAL_HOLD: begin
					if (hold_wake || xtal_wake) begin
						mode <= MVIC_RUN;
					end
				end
				default: begin
					mode <= MVIC_RUN;
				end
			endcase
		end
	end

	// Oscillator controls follow the mode one cycle later; crystal stays alive in crystal hold.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			standby_mode <= MVIC_RUN;
			osc_main_run <= 1'b1;
			osc_xtal_run <= 1'b1;
			core_wake    <= 1'b0;
		end else begin
			standby_mode <= mode;
			osc_main_run <= mode != MVIC_HOLD && mode != MVIC_XTAL_HOLD;
			osc_xtal_run <= mode != MVIC_HOLD;
			core_wake    <= standby_mode != MVIC_RUN && mode == MVIC_RUN;
		end
	end

	// Levels are nested strictly upward.
	a_nest_strict: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(accept && irq_level > lvl_stack[0]) |=> lvl_stack[0] > lvl_stack[1])
		else $error("nested level not above previous");

	// A presented request always outranks the level in service.
	a_req_above_service: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(irq_req && !$past(core_return)) |-> irq_level > $past(lvl_stack[0]))
		else $error("request not above service level");

	// The winner's level is not below that of an eligible request on vector 0.
	a_best_level: assert property (@(posedge ref_clk) disable iff (!rst_n)
		win_valid |-> (win_level >= vec_level[1:0] || !vec_req[0] || vec_level[1:0] <= lvl_stack[0]))
		else $error("lower level won arbitration");

	// Ties go to the smaller vector.
	a_tie_small: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(win_valid && vec_req[0] && vec_level[1:0] == win_level) |-> win_vec == 0)
		else $error("tie not resolved to smallest vector");

	// Fourth vector is requested by its base timer.
	a_vec_four_map: assert property (@(posedge ref_clk) disable iff (!rst_n)
		src_flag[SRC_BASE_TMR] |-> vec_req[3])
		else $error("base timer not on fourth vector");

	// Serial and UART groups reach their vectors.
	a_serial_map: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(src_flag[SRC_UART2_RX] |-> vec_req[6]) and (src_flag[SRC_UART1_TX] |-> vec_req[7]))
		else $error("serial source on wrong vector");

	// First two vectors never run at the plain high level.
	a_top_only: assert property (@(posedge ref_clk) disable iff (!rst_n)
		vec_level[1:0] != MVIC_LVL_HIGH && vec_level[3:2] != MVIC_LVL_HIGH)
		else $error("first vectors at high level");

	// Hold stops the main oscillators within two cycles of entry.
	a_hold_osc_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(mode == MVIC_HOLD) |=> !osc_main_run && !osc_xtal_run)
		else $error("oscillators run in hold");

	// Hold wake returns to run on the next edge.
	a_hold_wake: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(mode == MVIC_HOLD && hold_wake) |=> mode == MVIC_RUN)
		else $error("hold not ended by wake");

	// Crystal hold also ends on the base timer.
	a_xtal_wake: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(mode == MVIC_XTAL_HOLD && src_flag[SRC_BASE_TMR]) |=> mode == MVIC_RUN)
		else $error("crystal hold not ended by timer");

	// Halt ends on a pending interrupt.
	a_halt_wake: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(mode == MVIC_HALT && win_valid) |=> mode == MVIC_RUN)
		else $error("halt not ended by interrupt");

	// A pending flag with a free level is presented within two cycles while running.
	a_pending_kept: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(mode == MVIC_RUN && win_valid && !core_ack && !core_return && !halt_enter && !hold_enter
		&& !xtal_hold_enter)[*2] |-> irq_req)
		else $error("pending request dropped");

	// Flag list shows the selected vector's sources.
	a_list_shows: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(!accept && src_flag[SRC_EXT0] && list_vec_sel == 0) |=> vector_source_flag_list[SRC_EXT0])
		else $error("flag list missing source");

endmodule

// ### testbench/mvic_core_model.sv
// Behavioural processor core that takes vectored branches and ends services.
`timescale 1ns/1ps
module mvic_core_model (
	input  wire logic ref_clk,
	input  wire logic rst_n,
	input  wire logic irq_req,
	input  wire logic take_en,
	input  wire logic ret_go,
	output logic      core_ack,
	output logic      core_return
);
	// The core acks only while a request is shown, one cycle after it is told to take one.
	// Slow answers come from the bench holding take_en back for a few cycles.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			core_ack    <= 1'b0;
			core_return <= 1'b0;
		end else begin
			core_ack    <= take_en && irq_req;
			core_return <= ret_go;
		end
	end
endmodule

// ### testbench/multilevel_vectored_interrupt_ctrl_bench.sv
// Self-checking bench: random arbitration and nesting against a queue model, then standby entry and wake.
`timescale 1ns/1ps
module multilevel_vectored_interrupt_ctrl_bench;
	import mvic_pkg::*;
	logic [30:0] src_flag;                // Pending source flags.
	logic [30:0] vector_source_flag_list; // Flags of the chosen vector.
	logic [19:0] irq_vec_addr;            // Presented vector address.
	logic [9:0]  level_sel_high;          // Level choice per vector.
	logic [7:0]  port0_irq;               // Port 0 sources.
	logic [3:0]  list_vec_sel;            // Vector shown in the flag list.
	logic [1:0]  irq_level;
	logic [1:0]  level_in_service;
	logic [1:0]  standby_mode;
	logic        ref_clk;
	logic        rst_n;
	logic        take_en;
	logic        ret_go;
	logic        core_ack;
	logic        core_return;
	logic        halt_enter;
	logic        hold_enter;
	logic        xtal_hold_enter;
	logic        irq_req;
	logic        osc_main_run;
	logic        osc_xtal_run;
	logic        core_wake;
	logic        wake_seen;               // Sticky copy of the wake pulse.
	int          n_errors;
	int          samples_checked;
	int          seed;
	int          exp_lv;                  // Level the model expects to be presented.
	int          stk[$];                  // Model of the nesting stack.
	int          hold_wakes[5];

	mvic_ctrl mvic_ctrl_i (.ref_clk(ref_clk), .rst_n(rst_n), .src_flag(src_flag),
		.level_sel_high(level_sel_high), .core_ack(core_ack), .core_return(core_return),
		.list_vec_sel(list_vec_sel), .halt_enter(halt_enter), .hold_enter(hold_enter),
		.xtal_hold_enter(xtal_hold_enter), .port0_irq(port0_irq), .irq_req(irq_req),
		.irq_vec_addr(irq_vec_addr), .irq_level(irq_level), .level_in_service(level_in_service),
		.vector_source_flag_list(vector_source_flag_list), .standby_mode(standby_mode),
		.osc_main_run(osc_main_run), .osc_xtal_run(osc_xtal_run), .core_wake(core_wake));

	mvic_core_model mvic_core_model_i (.ref_clk(ref_clk), .rst_n(rst_n), .irq_req(irq_req),
		.take_en(take_en), .ret_go(ret_go), .core_ack(core_ack), .core_return(core_return));

	// Free-running 20 MHz clock.
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	// The wake pulse lasts one cycle, so it is caught here and cleared by the next entry pulse.
	always @(posedge ref_clk) begin
		wake_seen <= (core_wake === 1'b1) || (wake_seen && !halt_enter && !hold_enter && !xtal_hold_enter);
	end

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic results();
		if (n_errors == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Waits whole cycles and steps past the edge so outputs have settled.
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	// Vector of each source, from the member counts of the ten shared vectors.
	function automatic int src_vec(input int s);
		return s < 1 ? 0 : s < 2 ? 1 : s < 6 ? 2 : s < 10 ? 3 : s < 12 ? 4 : s < 15 ? 5 : s < 20 ? 6 : s < 23 ? 7 : s < 29 ? 8 : 9;
	endfunction

	function automatic logic [30:0] vmask(input int v);
		logic [30:0] m;
		m = '0;
		for (int s = 0; s < 31; s++) begin
			m[s] = src_vec(s) == v;
		end
		return m;
	endfunction

	// Predicts the presented request from flags, levels and the stack, then compares.
	task automatic cmp_irq();
		int best;
		int lv;
		int top;
		best = -1;
		exp_lv = 0;
		top = stk.size() ? stk[$] : 0;
		for (int v = 0; v < 10; v++) begin
			lv = level_sel_high[v] ? (v < 2 ? 3 : 2) : 1;
			if (|(src_flag & vmask(v)) && lv > top && lv > exp_lv) begin
				best = v;
				exp_lv = lv;
			end
		end
		check("irq_req", irq_req, best >= 0);
		if (best >= 0) begin
			check("irq_vec_addr", irq_vec_addr, 32'h3 + 8 * best);
			check("irq_level", irq_level, exp_lv);
		end
		check("flag_list", vector_source_flag_list, src_flag & vmask(list_vec_sel));
		check("level_in_service", level_in_service, top);
	endtask

	task automatic ret_one();
		@(posedge ref_clk) ret_go <= 1'b1;
		@(posedge ref_clk) ret_go <= 1'b0;
		void'(stk.pop_back());
		cyc(3);
		cmp_irq();
	endtask

	// Enters a standby mode, shows a source that must not wake it, then one that must.
	task automatic standby(input int kind, input int idle_src, input int wake_src, input logic [7:0] port);
		@(posedge ref_clk);
		src_flag        <= '0;
		port0_irq       <= '0;
		halt_enter      <= kind == 1;
		hold_enter      <= kind == 2;
		xtal_hold_enter <= kind == 3;
		@(posedge ref_clk);
		halt_enter      <= 1'b0;
		hold_enter      <= 1'b0;
		xtal_hold_enter <= 1'b0;
		cyc(3);
		check("standby_mode", standby_mode, kind);
		check("osc_main_run", osc_main_run, kind == 1);
		check("osc_xtal_run", osc_xtal_run, kind != 2);
		if (idle_src >= 0) begin
			@(posedge ref_clk) src_flag[idle_src] <= 1'b1;
			cyc(4);
			check("standby_mode", standby_mode, kind);
			check("irq_req", irq_req, 0);
		end
		@(posedge ref_clk);
		if (wake_src >= 0) src_flag[wake_src] <= 1'b1;
		port0_irq <= port;
		cyc(4);
		check("standby_mode", standby_mode, 0);
		check("osc_main_run", osc_main_run, 1);
		check("core_wake", wake_seen, 1);
	endtask

	task automatic do_reset();
		@(posedge ref_clk) rst_n <= 1'b0;
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		cyc(1);
		check("standby_mode", standby_mode, 0);
		check("osc_main_run", osc_main_run, 1);
		check("osc_xtal_run", osc_xtal_run, 1);
		check("irq_req", irq_req, 0);
	endtask

	// Watchdog sized well above the at most 5000 cycles the sequence needs.
	initial begin
		#2500000;
		n_errors++;
		results();
	end

	initial begin
		{src_flag, level_sel_high, port0_irq, list_vec_sel} = '0;
		{take_en, ret_go, halt_enter, hold_enter, xtal_hold_enter, wake_seen} = '0;
		rst_n = 1'b0;
		seed = 32'he1c1a989;
		hold_wakes = '{SRC_EXT0, SRC_EXT1, SRC_EXT2, SRC_EXT4, SRC_EXT5};
		do_reset();
		// Random flags and levels; random acks push levels, random returns pop them.
		for (int i = 0; i < 300; i++) begin
			@(posedge ref_clk);
			src_flag       <= 31'($random(seed) & $random(seed) & $random(seed));
			level_sel_high <= 10'($random(seed));
			list_vec_sel   <= 4'($unsigned($random(seed)) % 10);
			cyc(3);
			cmp_irq();
			if (irq_req === 1'b1 && exp_lv > 0 && $random(seed) % 2) begin
				repeat ($unsigned($random(seed)) % 3) @(posedge ref_clk);
				@(posedge ref_clk) take_en <= 1'b1;
				@(posedge ref_clk) take_en <= 1'b0;
				stk.push_back(exp_lv);
				cyc(3);
				cmp_irq();
			end
			if (stk.size() > 0 && $random(seed) % 3 == 0) ret_one();
		end
		while (stk.size() > 0) ret_one();
		standby(1, -1, SRC_ADC, 8'h00);
		foreach (hold_wakes[k]) standby(2, SRC_BASE_TMR, hold_wakes[k], 8'h00);
		standby(2, SRC_EXT3, -1, 8'h10);
		standby(3, SRC_EXT3, SRC_BASE_TMR, 8'h00);
		standby(3, SRC_EXT3, SRC_IR_FIRST, 8'h00);
		standby(3, SRC_EXT3, SRC_IR_SECOND, 8'h00);
		// Reset ends hold as well.
		@(posedge ref_clk);
		src_flag   <= '0;
		port0_irq  <= '0;
		hold_enter <= 1'b1;
		@(posedge ref_clk) hold_enter <= 1'b0;
		cyc(3);
		do_reset();
		results();
	end
endmodule
